// [rtl/float_operand_classifier.sv]
// operand decoder, classifier and invalid-operation trap for the float unit
//
// Behaviour
// - Two operand formats only: single 32 bits and double 64 bits.
// - Normalized significand is hidden one plus fraction, from 1.0 below 2.0.
// - True exponent is exponent field minus bias 127 single or 1023 double.
// - Exponent field all ones means reserved operand, whatever the fraction.
// - Zero exponent with zero fraction is zero; nonzero fraction is reserved.
// - Sign bit 0 means positive, 1 means negative.
// - Negation flips only the sign bit, exponent and fraction untouched.
// - Exponent neither all zeros nor all ones means a normalized number.
// - Positive and negative zero both recognised, differing only in sign.
// - Infinities, NaNs and denormals are all reserved operands.
// - Reserved operand raises invalid-operation trap unless op is a plain move.
// - No infinity, NaN or denormal is delivered as a result, except by a plain move.
// - Invalid operation from reserved operand reports trap type 101.
`timescale 1ns/1ps
module float_operand_classifier
  import fp_class_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // request from the instruction sequencer
  input  wire logic                  req_valid,
  input  req_t                       req,
  output logic                       req_ready,
  // response
  output logic                       rsp_valid,
  output logic                       rsp_is_double,
  output logic                       rsp_sign,
  output logic [DBL_EXP_W-1:0]       rsp_exp_field,
  output logic [DBL_FRAC_W-1:0]      rsp_frac_field,
  output logic [TEXP_W-1:0]          rsp_true_exp,
  output logic [SIGNIF_W-1:0]        rsp_signif,
  output cls_t                       rsp_cls,
  output rsv_t                       rsp_rsv,
  output logic [DBL_W-1:0]           rsp_result,
  output logic                       rsp_trap,
  output logic [2:0]                 rsp_trap_type
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EVAL = 3'b010,
    ST_DONE = 3'b100
  } fsm_t;

  // everything the block remembers, registered as one word
  typedef struct packed {
    fsm_t              fsm;
    logic              ready;
    req_t              req;
    logic              rsp_valid;
    logic              is_double;
    fields_t           fld;
    logic [DBL_W-1:0]  result;
    logic              trap;
    logic [2:0]        tt;
  } core_t;

  // reset image: idle, ready, positive-zero answer, no trap
  localparam core_t CORE_RST = '{
    fsm:       ST_IDLE,
    ready:     1'b1,
    req:       '{op: OP_MOVE, is_double: 1'b0, operand: RESULT_RST},
    rsp_valid: 1'b0,
    is_double: 1'b0,
    fld:       '{sign: 1'b0, exp_field: '0, frac_field: '0, true_exp: '0,
                 signif: '0, cls: CLS_ZERO, rsv: RSV_NONE},
    result:    RESULT_RST,
    trap:      1'b0,
    tt:        TT_NONE
  };

  // state register and its next value, then combinational helpers
  core_t             core_r;
  core_t             core_nxt;
  fields_t           fld_w;
  logic              reserved_w;
  logic              trap_w;
  logic [DBL_W-1:0]  sign_mask_w;
  logic [DBL_W-1:0]  fmt_mask_w;
  logic [DBL_W-1:0]  value_w;

  // ----------------------------------------------------------------
  // field decode of the captured operand
  // ----------------------------------------------------------------
  // purely combinational; it sees the captured operand, so its inputs
  // stay steady for the whole evaluate cycle
  fp_field_split u_split (
    .operand   (core_r.req.operand),
    .is_double (core_r.req.is_double),
    .fld       (fld_w)
  );

  // ----------------------------------------------------------------
  // per-format masks
  // ----------------------------------------------------------------
  // bits above a single operand are forced low so a stale upper word
  // from the sequencer never leaks into a single-precision result
  always_comb begin
    if (core_r.req.is_double) begin
      // double: sign at the top of the full word
      sign_mask_w = 64'h8000_0000_0000_0000;
      fmt_mask_w  = 64'hffff_ffff_ffff_ffff;
    end else begin
      // single: sign at bit 31, upper word cleared
      sign_mask_w = 64'h0000_0000_8000_0000;
      fmt_mask_w  = 64'h0000_0000_ffff_ffff;
    end
  end

  // ----------------------------------------------------------------
  // result and trap decision
  // ----------------------------------------------------------------
  always_comb begin
    reserved_w = (fld_w.cls == CLS_RESERVED);
    // a plain move hands the bit pattern over untouched, so no trap
    trap_w     = reserved_w && (core_r.req.op != OP_MOVE);
    value_w    = core_r.req.operand & fmt_mask_w;
    case (core_r.req.op)
      OP_MOVE: begin
        // bit pattern passes as it stands, reserved forms included
        value_w = core_r.req.operand & fmt_mask_w;
      end
      OP_NEG: begin
        // sign-magnitude: flipping the sign bit alone negates
        value_w = (core_r.req.operand ^ sign_mask_w) & fmt_mask_w;
      end
      OP_ABS: begin
        // clearing the sign bit gives the magnitude
        value_w = core_r.req.operand & ~sign_mask_w & fmt_mask_w;
      end
      OP_ARITH: begin
        // the arithmetic itself lives elsewhere; only the operand is screened
        value_w = core_r.req.operand & fmt_mask_w;
      end
      default: begin
        value_w = RESULT_RST;
      end
    endcase
    // a trapped operation delivers positive zero, never the reserved form
    if (trap_w) begin
      value_w = RESULT_RST;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: take, evaluate, answer
  // ----------------------------------------------------------------
  // one request in flight; the trade is three cycles per operand for a
  // single register stage and no queue
  always_comb begin
    core_nxt           = core_r;
    core_nxt.rsp_valid = 1'b0;
    case (core_r.fsm)
      ST_IDLE: begin
        // ready is high only here, so the take needs no extra gate
        if (req_valid) begin
          core_nxt.req   = req;
          core_nxt.ready = 1'b0;
          core_nxt.fsm   = ST_EVAL;
        end
      end
      ST_EVAL: begin
        // fields, result and trap land together with the valid pulse
        core_nxt.fld       = fld_w;
        core_nxt.is_double = core_r.req.is_double;
        core_nxt.result    = value_w;
        core_nxt.trap      = trap_w;
        core_nxt.tt        = trap_w ? TT_INVALID : TT_NONE;
        core_nxt.rsp_valid = 1'b1;
        core_nxt.fsm       = ST_DONE;
      end
      ST_DONE: begin
        // the answer cycle with the valid pulse high, then ready again for the next take
        core_nxt.ready = 1'b1;
        core_nxt.fsm   = ST_IDLE;
      end
      default: begin
        // a corrupted state word falls back to the reset image
        core_nxt = CORE_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register; clock enable low freezes everything
  // ----------------------------------------------------------------
  // ce low also stretches a pending valid pulse; a host must not
  // count on a take at an edge where ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_r <= CORE_RST;
    end else if (ce) begin
      core_r <= core_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  // handshake
  assign req_ready      = core_r.ready;
  assign rsp_valid      = core_r.rsp_valid;

  // decoded fields of the answered operand
  assign rsp_is_double  = core_r.is_double;
  assign rsp_sign       = core_r.fld.sign;
  assign rsp_exp_field  = core_r.fld.exp_field;
  assign rsp_frac_field = core_r.fld.frac_field;
  assign rsp_true_exp   = core_r.fld.true_exp;
  assign rsp_signif     = core_r.fld.signif;
  assign rsp_cls        = core_r.fld.cls;
  assign rsp_rsv        = core_r.fld.rsv;

  // result and trap report
  assign rsp_result     = core_r.result;
  assign rsp_trap       = core_r.trap;
  assign rsp_trap_type  = core_r.tt;

endmodule

// [rtl/fp_class_pkg.sv]
// shared constants, enumerations and carriers for the operand classifier
package fp_class_pkg;

  // ----------------------------------------------------------------
  // operand formats
  // ----------------------------------------------------------------
  localparam int unsigned SGL_W       = 32;
  localparam int unsigned DBL_W       = 64;
  localparam int unsigned SGL_EXP_W   = 8;
  localparam int unsigned SGL_FRAC_W  = 23;
  localparam int unsigned DBL_EXP_W   = 11;
  localparam int unsigned DBL_FRAC_W  = 52;
  localparam int unsigned SGL_SIGN_POS = 31;
  localparam int unsigned DBL_SIGN_POS = 63;
  localparam int unsigned SGL_EXP_LSB  = 23;
  localparam int unsigned DBL_EXP_LSB  = 52;
  localparam int unsigned TEXP_W       = 12;
  localparam int unsigned SIGNIF_W     = 53;

  // exponent bias per format
  localparam logic [TEXP_W-1:0] SGL_BIAS = 12'h07f;
  localparam logic [TEXP_W-1:0] DBL_BIAS = 12'h3ff;

  // trap type codes
  localparam logic [2:0] TT_NONE    = 3'h0;
  localparam logic [2:0] TT_INVALID = 3'h5;

  // reset values
  localparam logic [DBL_W-1:0] RESULT_RST = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_MOVE  = 2'h0,  // plain move, no conversion
    OP_NEG   = 2'h1,  // sign inversion
    OP_ABS   = 2'h2,  // sign clear
    OP_ARITH = 2'h3   // arithmetic or converting use of the operand
  } op_t;

  typedef enum logic [1:0] {
    CLS_NORMAL   = 2'h0,
    CLS_ZERO     = 2'h1,
    CLS_RESERVED = 2'h2
  } cls_t;

  typedef enum logic [1:0] {
    RSV_NONE   = 2'h0,
    RSV_INF    = 2'h1,
    RSV_NAN    = 2'h2,
    RSV_DENORM = 2'h3
  } rsv_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    op_t              op;
    logic             is_double;
    logic [DBL_W-1:0] operand;
  } req_t;

  typedef struct packed {
    logic                  sign;
    logic [DBL_EXP_W-1:0]  exp_field;
    logic [DBL_FRAC_W-1:0] frac_field;
    logic [TEXP_W-1:0]     true_exp;
    logic [SIGNIF_W-1:0]   signif;
    cls_t                  cls;
    rsv_t                  rsv;
  } fields_t;

endpackage

// [rtl/fp_field_split.sv]
// combinational split and classification of one floating-point operand
`timescale 1ns/1ps
module fp_field_split
  import fp_class_pkg::*;
(
  // operand in
  input  wire logic [DBL_W-1:0] operand,
  input  wire logic             is_double,
  // decoded fields out
  output fields_t               fld
);

  logic [DBL_EXP_W-1:0]  exp_v;
  logic [DBL_FRAC_W-1:0] frac_v;
  logic                  exp_ones;
  logic                  exp_zero;
  logic                  frac_zero;

  // ----------------------------------------------------------------
  // field extraction, sign at the top of each format
  // ----------------------------------------------------------------
  always_comb begin
    if (is_double) begin
      exp_v    = operand[DBL_EXP_LSB +: DBL_EXP_W];
      frac_v   = operand[DBL_FRAC_W-1:0];
      fld.sign = operand[DBL_SIGN_POS];
      exp_ones = &operand[DBL_EXP_LSB +: DBL_EXP_W];
    end else begin
      exp_v    = {3'h0, operand[SGL_EXP_LSB +: SGL_EXP_W]};
      frac_v   = {29'h0, operand[SGL_FRAC_W-1:0]};
      fld.sign = operand[SGL_SIGN_POS];
      exp_ones = &operand[SGL_EXP_LSB +: SGL_EXP_W];
    end
    exp_zero       = (exp_v == '0);
    frac_zero      = (frac_v == '0);
    fld.exp_field  = exp_v;
    fld.frac_field = frac_v;
    // unbiased exponent, two's complement
    fld.true_exp   = TEXP_W'({1'b0, exp_v}) - (is_double ? DBL_BIAS : SGL_BIAS);
    // hidden one above the binary point, fraction left aligned below it
    fld.signif     = is_double ? {1'b1, frac_v}
                               : {1'b1, frac_v[SGL_FRAC_W-1:0], 29'h0};
    // classification; all-ones exponent is reserved whatever the fraction
    if (exp_ones) begin
      fld.cls = CLS_RESERVED;
      fld.rsv = frac_zero ? RSV_INF : RSV_NAN;
    end else if (exp_zero && frac_zero) begin
      fld.cls = CLS_ZERO;
      fld.rsv = RSV_NONE;
    end else if (exp_zero) begin
      fld.cls = CLS_RESERVED;
      fld.rsv = RSV_DENORM;
    end else begin
      fld.cls = CLS_NORMAL;
      fld.rsv = RSV_NONE;
    end
  end

endmodule

// [testbench/float_operand_classifier_properties.sv]
// concurrent checks on the operand classifier ports
`timescale 1ns/1ps
module float_operand_classifier_properties
  import fp_class_pkg::*;
(
  // clock and reset
  input logic        clk,
  input logic        rst,
  input logic        ce,
  // request
  input logic        req_valid,
  input req_t        req,
  input logic        req_ready,
  // response
  input logic        rsp_valid,
  input logic        rsp_is_double,
  input logic        rsp_sign,
  input logic [10:0] rsp_exp_field,
  input logic [51:0] rsp_frac_field,
  input logic [11:0] rsp_true_exp,
  input logic [52:0] rsp_signif,
  input cls_t        rsp_cls,
  input logic [63:0] rsp_result,
  input logic        rsp_trap,
  input logic [2:0]  rsp_trap_type
);
  // copy of the taken request; the bus need not hold it after the take
  req_t        q_r;
  logic        take, d, rsv;
  logic [10:0] ex, ones;
  logic [51:0] fr;
  assign take = ce && req_valid && req_ready;
  assign d    = q_r.is_double;
  assign ex   = d ? q_r.operand[62:52] : {3'h0, q_r.operand[30:23]};
  assign fr   = d ? q_r.operand[51:0] : {29'h0, q_r.operand[22:0]};
  assign ones = d ? 11'h7ff : 11'h0ff;
  assign rsv  = ex == ones || (ex == 11'h0 && fr != 52'h0);
  always_ff @(posedge clk or posedge rst)
    if (rst) q_r <= '0;
    else if (take) q_r <= req;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_lat; take ##1 ce [*2] |-> rsp_valid; endproperty
  a_lat: assert property (p_lat) else $error("answer late");
  property p_rdy; take ##1 ce [*3] |->
    !$past(req_ready) && !$past(req_ready, 2) && req_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_cls; rsp_valid |-> (rsp_cls == CLS_RESERVED) == rsv; endproperty
  a_cls: assert property (p_cls) else $error("reserved class");
  property p_zero; rsp_valid && ex == 11'h0 && fr == 52'h0 |-> rsp_cls == CLS_ZERO; endproperty
  a_zero: assert property (p_zero) else $error("zero class");
  property p_norm; rsp_valid && !rsv && ex != 11'h0 |-> rsp_cls == CLS_NORMAL &&
    rsp_signif == (d ? {1'b1, fr} : {1'b1, fr[22:0], 29'h0}); endproperty
  a_norm: assert property (p_norm) else $error("normal class");
  property p_bias; rsp_valid |-> rsp_true_exp == {1'b0, ex} - (d ? 12'h3ff : 12'h07f); endproperty
  a_bias: assert property (p_bias) else $error("true exponent");
  property p_fld; rsp_valid |-> rsp_is_double == d && rsp_exp_field == ex &&
    rsp_frac_field == fr && rsp_sign == q_r.operand[d ? 63 : 31]; endproperty
  a_fld: assert property (p_fld) else $error("field split");
  property p_trap; rsp_valid |-> rsp_trap == (rsv && q_r.op != OP_MOVE); endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_tt; rsp_valid |->
    rsp_trap_type == ((rsv && q_r.op != OP_MOVE) ? 3'h5 : 3'h0); endproperty
  a_tt: assert property (p_tt) else $error("trap type");
  property p_zres; rsp_valid && rsv && q_r.op != OP_MOVE |-> rsp_result == 64'h0; endproperty
  a_zres: assert property (p_zres) else $error("reserved result");
  property p_neg; rsp_valid && q_r.op == OP_NEG && !rsv |-> rsp_result == (d ? q_r.operand ^
    {1'b1, 63'h0} : {32'h0, ~q_r.operand[31], q_r.operand[30:0]}); endproperty
  a_neg: assert property (p_neg) else $error("negate");
endmodule

bind float_operand_classifier float_operand_classifier_properties chk_i (
  .clk, .rst, .ce, .req_valid, .req, .req_ready, .rsp_valid, .rsp_is_double, .rsp_sign,
  .rsp_exp_field, .rsp_frac_field, .rsp_true_exp, .rsp_signif, .rsp_cls, .rsp_result,
  .rsp_trap, .rsp_trap_type
);

// [testbench/fp_host_model.sv]
// host-side model that offers operands to the classifier
`timescale 1ns/1ps
module fp_host_model
  import fp_class_pkg::*;
(
  // clock
  input  logic clk,
  // request handshake
  input  logic req_ready,
  output logic req_valid,
  output req_t req
);
  // idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // offer after gap idle cycles, hold until the take edge
  task automatic send(input req_t r, input int gap);
    repeat (gap) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b1;
    req = r;
    while (!req_ready) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req = ~r;  // released: inverse, so stale data never looks valid
  endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the operand classifier
`timescale 1ns/1ps
module tb_top
  import fp_class_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce  = 1'b1;  // dropped now and then while an answer is pending
  logic        req_valid, req_ready, rsp_valid, rsp_is_double, rsp_sign, rsp_trap;
  req_t        req;
  logic [10:0] rsp_exp_field;
  logic [51:0] rsp_frac_field;
  logic [11:0] rsp_true_exp;
  logic [52:0] rsp_signif;
  cls_t        rsp_cls;
  rsv_t        rsp_rsv;
  logic [63:0] rsp_result, x;
  logic [2:0]  rsp_trap_type;
  logic [31:0] seed = 32'hf7506c2b, k;
  int          n_mismatch = 0, num_checks = 0;
  logic [64:0] vec [13] = '{65'h0_dead_beef_0000_0000, 65'h0_0000_0000_8000_0000,
    65'h0_0000_0000_7f80_0000, 65'h0_0000_0000_ffc0_0000, 65'h0_0000_0000_0000_0001,
    65'h0_0000_0000_3fc0_0000, 65'h0_0000_0000_0080_0000, 65'h0_0000_0000_ff7f_ffff,
    65'h1_8000_0000_0000_0000, 65'h1_fff0_0000_0000_0000, 65'h1_000f_ffff_ffff_ffff,
    65'h1_3ff8_0000_0000_0000, 65'h1_7fef_ffff_ffff_ffff};

  always #25 clk = ~clk;

  float_operand_classifier float_operand_classifier_i (.clk, .rst, .ce, .req_valid, .req,
    .req_ready, .rsp_valid, .rsp_is_double, .rsp_sign, .rsp_exp_field, .rsp_frac_field,
    .rsp_true_exp, .rsp_signif, .rsp_cls, .rsp_rsv, .rsp_result, .rsp_trap, .rsp_trap_type);
  fp_host_model fp_host_model_i (.clk, .req_ready, .req_valid, .req);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task test_done();
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one transfer, then compare every field with the reference model; the significand only for normal operands
  task automatic run(input req_t r, input int gap, input int hold);
    logic d, s, tr;
    logic [10:0] e, o;
    logic [51:0] f;
    logic [63:0] res;
    int c, n;
    fp_host_model_i.send(r, gap);
    // freeze with the answer pending: no valid pulse, ready stays low
    if (hold > 0) begin
      ce = 1'b0;
      repeat (hold) begin
        @(posedge clk);
        #1;
        chk(rsp_valid, 1'b0);
        chk(req_ready, 1'b0);
      end
      ce = 1'b1;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!rsp_valid && n < 8);
    d = r.is_double;
    s = r.operand[d ? 63 : 31];
    e = d ? r.operand[62:52] : {3'h0, r.operand[30:23]};
    f = d ? r.operand[51:0] : {29'h0, r.operand[22:0]};
    o = d ? 11'h7ff : 11'h0ff;
    c = (e == o || (e == 0 && f != 0)) ? 2 : (e == 0 ? 1 : 0);
    tr = c == 2 && r.op != OP_MOVE;
    res = d ? r.operand : {32'h0, r.operand[31:0]};
    if (r.op == OP_NEG) res[d ? 63 : 31] = ~s;
    if (r.op == OP_ABS) res[d ? 63 : 31] = 1'b0;
    if (tr) res = 64'h0;
    chk(n, 1);
    chk(req_ready, 1'b0);
    chk(rsp_is_double, d);
    chk(rsp_sign, s);
    chk(rsp_exp_field, e);
    chk(rsp_frac_field, f);
    chk(rsp_true_exp, 12'({1'b0, e} - (d ? 12'h3ff : 12'h07f)));
    chk(rsp_cls, c);
    chk(rsp_rsv, c != 2 ? 0 : e == 0 ? 3 : f == 0 ? 1 : 2);
    if (c == 0) chk(rsp_signif, d ? {1'b1, f} : {1'b1, f[22:0], 29'h0});
    chk(rsp_trap, tr);
    chk(rsp_trap_type, tr ? 3'h5 : 3'h0);
    chk(rsp_result, res);
  endtask

  // corner table for every op back to back, then random traffic
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(req_ready, 1'b1);
    chk(rsp_valid, 1'b0);
    for (int op = 0; op < 4; op++)
      foreach (vec[i]) run({op[1:0], vec[i]}, 0, 0);
    repeat (300) begin
      x = {xs(), xs()};
      k = xs();
      if (k[1:0] == 2'h1) x &= ~64'h7ff0_0000_7f80_0000;
      if (k[1:0] == 2'h2) x |= 64'h7ff0_0000_7f80_0000;
      if (k[2]) x &= k[3] ? 64'hfff0_0000_0000_0000 : 64'hffff_ffff_ff80_0000;
      run({k[5:4], k[3], x}, k[7:6], k[9:8]);
    end
    test_done();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #1_000_000;
    n_mismatch++;
    test_done();
  end
endmodule
